// ---- spti_consts.svh ----
// Register offsets, field positions and reset values of the threshold block
`ifndef SPTI_CONSTS_SVH
`define SPTI_CONSTS_SVH
`define SPTI_ADDR_TH_L_LO 8'h84
`define SPTI_ADDR_TH_L_HI 8'h85
`define SPTI_ADDR_TH_H_LO 8'h86
`define SPTI_ADDR_TH_H_HI 8'h87
`define SPTI_ADDR_STATUS 8'h93
`define SPTI_ADDR_CHCFG 8'hB5
`define SPTI_ADDR_PERSIST 8'hBD
`define SPTI_ADDR_ENABLE 8'hF9
`define SPTI_FLAG_BIT 3
`define SPTI_IEN_BIT 3
`define SPTI_CHSEL_MSB 2
`define SPTI_PERS_MSB 3
`define SPTI_BYTE_RST 8'h00
`define SPTI_THR_RST 16'h0000
`define SPTI_CHSEL_RST 3'h0
`define SPTI_PERS_RST 4'h0
`define SPTI_NUM_CH 5
`define SPTI_CH_LAST 3'h4
`endif

// ---- spti_pkg.sv ----
// Shared types of the spectral threshold interrupt block
package spti_pkg;
    typedef struct packed {
        logic [15:0] low;
        logic [15:0] high;
    } spti_window_type;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spti_req_type;
endpackage

// ---- spti_persist.sv ----
// Consecutive out-of-window counter that fires at the persistence setting
`timescale 1ns/100ps
`include "spti_consts.svh"
module spti_persist #(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Measurement result
    input wire logic meas_valid,
    input wire logic outside,
    input wire logic [CNT_W-1:0] limit,
    // Event
    output logic fire
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic fire_reg;

    // Saturates so a long excursion keeps firing instead of wrapping
    always_comb begin
        cnt_next = cnt_reg;
        if (outside && (cnt_reg != {CNT_W{1'b1}})) begin
            cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
        end else if (meas_valid) begin
            cnt_reg <= outside ? cnt_next : '0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fire_reg <= 1'b0;
        end else begin
            fire_reg <= meas_valid && outside && (cnt_next >= limit);
        end
    end

    assign fire = fire_reg;

    fire_cause_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fire |-> $past(meas_valid) && $past(outside))
        else $error("persistence fired without an outside measurement");

    inside_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        meas_valid && !outside |=> cnt_reg == '0 && !fire)
        else $error("inside measurement did not reset persistence");
endmodule

// ---- spti_top.sv ----
// Window comparator with byte-latched low threshold and persistence interrupt
`timescale 1ns/100ps
`include "spti_consts.svh"
// What this block does
// - Low threshold is low byte at lower offset, high byte at next offset.
// - With the enable set, value below low or above high threshold at persistence sets the flag and interrupt.
// - Low-byte write is latched; applied together with the high-byte write.
// - High threshold built from two bytes, low byte first; both reset zero.
// - Channel select picks channel for thresholds, persistence and saturation.
// - Interrupt only produced while the spectral interrupt enable is set.
// - Consecutive outside measurements counted; fire at persistence setting.
// - Event recorded in status bit 3; write one clears, zero keeps.
module spti_top
    import spti_pkg::*;
#(
    parameter int PERS_W = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port from the serial interface
    input wire spti_req_type reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    // Measurement engine
    input wire logic meas_valid,
    input wire logic [16*`SPTI_NUM_CH-1:0] ch_data,
    input wire logic [`SPTI_NUM_CH-1:0] ch_sat,
    // Status outputs
    output logic sat_selected,
    output logic spectral_irq
);
    spti_window_type win_reg;
    logic [7:0] low_byte_latch_reg;
    logic [2:0] chsel_reg;
    logic [PERS_W-1:0] persist_count_reg;
    logic spectral_irq_enable_reg;
    logic spectral_threshold_flag_reg;
    logic [7:0] rdata_reg;
    logic rd_valid_reg;
    logic sat_reg;
    logic irq_reg;
    logic [2:0] chsel_eff;
    logic [15:0] sel_value;
    logic outside_w;
    logic fire_w;
    logic wr_l_lo;
    logic wr_l_hi;
    logic wr_h_lo;
    logic wr_h_hi;
    logic wr_status;

    assign wr_l_lo = reg_req.wr_en && (reg_req.addr == `SPTI_ADDR_TH_L_LO);
    assign wr_l_hi = reg_req.wr_en && (reg_req.addr == `SPTI_ADDR_TH_L_HI);
    assign wr_h_lo = reg_req.wr_en && (reg_req.addr == `SPTI_ADDR_TH_H_LO);
    assign wr_h_hi = reg_req.wr_en && (reg_req.addr == `SPTI_ADDR_TH_H_HI);
    assign wr_status = reg_req.wr_en && (reg_req.addr == `SPTI_ADDR_STATUS);

    // Pending low byte; never reaches the comparator on its own
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_byte_latch_reg <= `SPTI_BYTE_RST;
        end else if (wr_l_lo) begin
            low_byte_latch_reg <= reg_req.wdata;
        end
    end

    // Both halves land at once so the low threshold is never half updated
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            win_reg.low <= `SPTI_THR_RST;
        end else if (wr_l_hi) begin
            win_reg.low <= {reg_req.wdata, low_byte_latch_reg};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            win_reg.high <= `SPTI_THR_RST;
        end else if (wr_h_lo) begin
            win_reg.high[7:0] <= reg_req.wdata;
        end else if (wr_h_hi) begin
            win_reg.high[15:8] <= reg_req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            chsel_reg <= `SPTI_CHSEL_RST;
            persist_count_reg <= `SPTI_PERS_RST;
            spectral_irq_enable_reg <= 1'b0;
        end else if (reg_req.wr_en) begin
            case (reg_req.addr)
                `SPTI_ADDR_CHCFG: begin
                    chsel_reg <= reg_req.wdata[`SPTI_CHSEL_MSB:0];
                end
                `SPTI_ADDR_PERSIST: begin
                    persist_count_reg <= reg_req.wdata[`SPTI_PERS_MSB:0];
                end
                `SPTI_ADDR_ENABLE: begin
                    spectral_irq_enable_reg <= reg_req.wdata[`SPTI_IEN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Codes above the last channel fall back to the first channel
    assign chsel_eff = (chsel_reg > `SPTI_CH_LAST) ? `SPTI_CHSEL_RST
                                                   : chsel_reg;
    assign sel_value = ch_data[16*chsel_eff +: 16];

    // Unsigned, strict on both sides
    assign outside_w = (sel_value < win_reg.low) ||
                       (sel_value > win_reg.high);

    spti_persist #(
        .CNT_W(PERS_W)
    ) u_persist (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .meas_valid(meas_valid),
        .outside(outside_w),
        .limit(persist_count_reg),
        .fire(fire_w)
    );

    // A new event beats a clear arriving in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            spectral_threshold_flag_reg <= 1'b0;
        end else if (fire_w && spectral_irq_enable_reg) begin
            spectral_threshold_flag_reg <= 1'b1;
        end else if (wr_status && reg_req.wdata[`SPTI_FLAG_BIT]) begin
            spectral_threshold_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= spectral_threshold_flag_reg &&
                       spectral_irq_enable_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sat_reg <= 1'b0;
        end else begin
            sat_reg <= ch_sat[chsel_eff];
        end
    end

    // Reads: unmapped offsets and reserved bits return zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= `SPTI_BYTE_RST;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_req.rd_en;
            if (reg_req.rd_en) begin
                rdata_reg <= `SPTI_BYTE_RST;
                case (reg_req.addr)
                    `SPTI_ADDR_TH_L_LO: begin
                        rdata_reg <= win_reg.low[7:0];
                    end
                    `SPTI_ADDR_TH_L_HI: begin
                        rdata_reg <= win_reg.low[15:8];
                    end
                    `SPTI_ADDR_TH_H_LO: begin
                        rdata_reg <= win_reg.high[7:0];
                    end
                    `SPTI_ADDR_TH_H_HI: begin
                        rdata_reg <= win_reg.high[15:8];
                    end
                    `SPTI_ADDR_CHCFG: begin
                        rdata_reg[`SPTI_CHSEL_MSB:0] <= chsel_reg;
                    end
                    `SPTI_ADDR_PERSIST: begin
                        rdata_reg[`SPTI_PERS_MSB:0] <= persist_count_reg;
                    end
                    `SPTI_ADDR_ENABLE: begin
                        rdata_reg[`SPTI_IEN_BIT] <= spectral_irq_enable_reg;
                    end
                    `SPTI_ADDR_STATUS: begin
                        rdata_reg[`SPTI_FLAG_BIT] <=
                            spectral_threshold_flag_reg;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rd_valid = rd_valid_reg;
    assign sat_selected = sat_reg;
    assign spectral_irq = irq_reg;

    low_commit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_l_hi |=> win_reg.low ==
            {$past(reg_req.wdata), $past(low_byte_latch_reg)})
        else $error("low threshold not committed from both bytes");

    low_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_l_lo && !wr_l_hi |=> $stable(win_reg.low))
        else $error("low byte write changed the active threshold");

    high_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_h_lo |=> win_reg.high[7:0] == $past(reg_req.wdata))
        else $error("high threshold low byte not stored");

    equal_inside_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (sel_value == win_reg.low || sel_value == win_reg.high) &&
        win_reg.low <= win_reg.high |-> !outside_w)
        else $error("value equal to a threshold seen as outside");

    flag_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fire_w && spectral_irq_enable_reg |=> spectral_threshold_flag_reg
        ##1 (irq_reg || !$past(spectral_irq_enable_reg)))
        else $error("persistence event did not raise flag and irq");

    enable_gate_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        $rose(spectral_threshold_flag_reg) |->
            $past(spectral_irq_enable_reg) && $past(fire_w))
        else $error("flag set while interrupt enable was clear");

    zero_keeps_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_status && !reg_req.wdata[`SPTI_FLAG_BIT] &&
        spectral_threshold_flag_reg |=> spectral_threshold_flag_reg)
        else $error("writing zero cleared the status flag");

    one_clears_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_status && reg_req.wdata[`SPTI_FLAG_BIT] && !fire_w
        |=> !spectral_threshold_flag_reg)
        else $error("writing one did not clear the status flag");

    sat_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sat_reg == $past(ch_sat[chsel_eff]))
        else $error("saturation not taken from the selected channel");
endmodule

// ---- spti_host_model.sv ----
// Host-side byte access model for the threshold register port
`timescale 1ns/100ps
`include "spti_consts.svh"
module spti_host_model
    import spti_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output spti_req_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid
);
    initial begin
        reg_req = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask

    // Both halves back to back so the latched low byte is committed
    task automatic wr_low_pair(input logic [15:0] v);
        @(posedge sys_clk);
        reg_req <= '{1'b1, 1'b0, `SPTI_ADDR_TH_L_LO, v[7:0]};
        @(posedge sys_clk);
        reg_req <= '{1'b1, 1'b0, `SPTI_ADDR_TH_L_HI, v[15:8]};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        @(posedge sys_clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        reg_req <= '0;
        #1;
        d = reg_rdata;
        ok = reg_rd_valid;
    endtask
endmodule

// ---- tb.sv ----
// Self-checking bench of the spectral threshold interrupt block
`timescale 1ns/100ps
`include "spti_consts.svh"
module tb;
    import spti_pkg::*;
    logic sys_clk;
    logic reset_n;
    spti_req_type reg_req;
    logic [7:0] reg_rdata;
    logic reg_rd_valid;
    logic meas_valid;
    logic [16*`SPTI_NUM_CH-1:0] ch_data;
    logic [`SPTI_NUM_CH-1:0] ch_sat;
    logic sat_selected;
    logic spectral_irq;
    int n_errors = 0;
    int n_compared = 0;

    spti_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .meas_valid(meas_valid), .ch_data(ch_data), .ch_sat(ch_sat),
        .sat_selected(sat_selected), .spectral_irq(spectral_irq));
    spti_host_model host_u (.sys_clk(sys_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_u.rd(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask

    // Selected value on one channel, all others well inside the window
    task automatic meas(input int ch, input logic [15:0] v, input logic irq);
        logic [16*`SPTI_NUM_CH-1:0] d;
        d = {`SPTI_NUM_CH{16'h1800}};
        d[16*ch +: 16] = v;
        @(posedge sys_clk);
        ch_data <= d;
        meas_valid <= 1'b1;
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({7'h00, spectral_irq}, {7'h00, irq});
    endtask

    task automatic clear_flag;
        host_u.wr(`SPTI_ADDR_STATUS, 8'h08);
        rchk(`SPTI_ADDR_STATUS, 8'h00);
        chk({7'h00, spectral_irq}, 8'h00);
    endtask

    task automatic sat_chk(input logic [4:0] s, input logic exp);
        @(posedge sys_clk);
        ch_sat <= s;
        repeat (2) @(posedge sys_clk);
        #1 chk({7'h00, sat_selected}, {7'h00, exp});
    endtask

    initial begin
        #1000000;
        n_errors++;
        end_of_test();
    end

    initial begin
        reset_n = 1'b0;
        meas_valid = 1'b0;
        ch_data = '0;
        ch_sat = '0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk(`SPTI_ADDR_TH_L_HI, `SPTI_BYTE_RST);
        rchk(`SPTI_ADDR_TH_H_LO, 8'h00);
        rchk(`SPTI_ADDR_TH_H_HI, 8'h00);
        rchk(8'h10, 8'h00);
        $display("test reset values done");
        host_u.wr(`SPTI_ADDR_TH_L_LO, 8'h34);
        rchk(`SPTI_ADDR_TH_L_LO, 8'h00);
        host_u.wr(`SPTI_ADDR_TH_L_HI, 8'h12);
        rchk(`SPTI_ADDR_TH_L_LO, 8'h34);
        rchk(`SPTI_ADDR_TH_L_HI, 8'h12);
        host_u.wr_low_pair(16'h1234);
        host_u.wr(`SPTI_ADDR_TH_H_LO, 8'h00);
        host_u.wr(`SPTI_ADDR_TH_H_HI, 8'h20);
        rchk(`SPTI_ADDR_TH_H_HI, 8'h20);
        host_u.wr(`SPTI_ADDR_PERSIST, 8'h02);
        host_u.wr(`SPTI_ADDR_ENABLE, 8'h08);
        rchk(`SPTI_ADDR_PERSIST, 8'h02);
        rchk(`SPTI_ADDR_ENABLE, 8'h08);
        $display("test threshold bytes done");
        for (int ch = 0; ch < `SPTI_NUM_CH; ch++) begin
            host_u.wr(`SPTI_ADDR_CHCFG, 8'(ch));
            rchk(`SPTI_ADDR_CHCFG, 8'(ch));
            meas((ch + 1) % `SPTI_NUM_CH, 16'h0100, 1'b0);
            meas(ch, 16'h0100, 1'b0);
            meas(ch, 16'h0100, 1'b1);
            rchk(`SPTI_ADDR_STATUS, 8'h08);
            host_u.wr(`SPTI_ADDR_STATUS, 8'h00);
            rchk(`SPTI_ADDR_STATUS, 8'h08);
            clear_flag();
            sat_chk(5'(1 << ch), 1'b1);
            sat_chk(5'h1F ^ 5'(1 << ch), 1'b0);
        end
        host_u.wr(`SPTI_ADDR_CHCFG, 8'h05);
        rchk(`SPTI_ADDR_CHCFG, 8'h05);
        sat_chk(5'h01, 1'b1);
        sat_chk(5'h1E, 1'b0);
        $display("test channel select done");
        host_u.wr(`SPTI_ADDR_CHCFG, 8'h00);
        meas(0, 16'h1234, 1'b0);
        meas(0, 16'h1234, 1'b0);
        meas(0, 16'h2000, 1'b0);
        meas(0, 16'h2000, 1'b0);
        meas(0, 16'h2001, 1'b0);
        meas(0, 16'h2001, 1'b1);
        clear_flag();
        meas(0, 16'h1800, 1'b0);
        meas(0, 16'h1233, 1'b0);
        meas(0, 16'h1800, 1'b0);
        meas(0, 16'h1233, 1'b0);
        $display("test window edges done");
        meas(0, 16'h1233, 1'b1);
        host_u.wr(`SPTI_ADDR_ENABLE, 8'h00);
        rchk(`SPTI_ADDR_STATUS, 8'h08);
        chk({7'h00, spectral_irq}, 8'h00);
        clear_flag();
        meas(0, 16'h0001, 1'b0);
        rchk(`SPTI_ADDR_STATUS, 8'h00);
        $display("test enable done");
        end_of_test();
    end
endmodule
